// ### cprs_pkg.sv
//------------------------------------------------------------
// power and reset sequencing constants
//------------------------------------------------------------
package cprs_pkg;
   // clock and timing
   localparam int CLK_HZ = 40_000_000;
   localparam int POR_MIN_MS = 2;
   localparam int POR_MIN_CYCLES = (POR_MIN_MS * CLK_HZ + 999) / 1000;
   localparam int RELEASE_MAX_CLKS = 2;
   localparam int POR_CNT_W = 17;

   // bus group widths
   localparam int REQ_W = 5;
   localparam int RESP_W = 3;
   localparam int ADDR_W = 29;
   localparam int DATA_W = 64;
   localparam int DINV_W = 4;
   localparam int STRAP_W = 8;

   // reset values
   localparam logic [REQ_W-1:0] REQ_IDLE_N = 5'h1f;
   localparam logic [RESP_W-1:0] RESP_IDLE_N = 3'h7;
   localparam logic [POR_CNT_W-1:0] POR_CNT_ZERO = 17'h00000;

   // sequencer states, gray along reset -> release -> run
   typedef enum logic [1:0] {
      ST_IN_RESET = 2'h0,
      ST_RELEASE = 2'h1,
      ST_RUN = 2'h3,
      ST_FLOAT = 2'h2
   } cprs_state_e;

   // values caught at reset release
   typedef struct packed {
      logic soft_init;
      logic float_out;
      logic [STRAP_W-1:0] cfg;
   } cprs_straps_s;

   // captured request from the other agent
   typedef struct packed {
      logic [REQ_W-1:0] cmd;
      logic [ADDR_W-1:0] addr;
   } cprs_req_s;
endpackage

// ### cprs_bitrev.sv
`timescale 1ns/1ps
module cprs_bitrev #(
   parameter int W = 8
) (
   // data and selector
   input wire logic [W-1:0] din_in,
   input wire logic rev_in,
   // result
   output logic [W-1:0] dout_out
);
   // one mux per bit, swapping ends when reversal is selected
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign dout_out[i] = rev_in ? din_in[W-1-i] : din_in[i];
      end
   endgenerate
endmodule

// ### cprs_top.sv
`timescale 1ns/1ps
module cprs_top #(
   parameter int POR_MIN_CYC = cprs_pkg::POR_MIN_CYCLES
) (
   // clock and block reset
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   // system controller
   input wire logic SUPPLY_OK_IN,
   input wire logic RESET_N_IN,
   input wire logic INIT_N_IN,
   input wire logic SYS_MGMT_IRQ_N_IN,
   input wire logic [cprs_pkg::STRAP_W-1:0] STRAP_CFG_IN,
   // core side status
   output logic CORE_RESET_OUT,
   output logic CACHE_INVAL_OUT,
   output logic [cprs_pkg::STRAP_W-1:0] STRAP_CFG_OUT,
   output logic BIT_REVERSE_OUT,
   output logic OUTPUTS_FLOAT_OUT,
   output logic RESET_SHORT_OUT,
   // core side transmit
   input wire logic TXN_VALID_IN,
   input wire logic [cprs_pkg::REQ_W-1:0] TXN_CMD_IN,
   input wire logic [cprs_pkg::ADDR_W-1:0] TXN_ADDR_IN,
   output logic TXN_READY_OUT,
   input wire logic DATA_DRIVE_IN,
   input wire logic [cprs_pkg::DATA_W-1:0] TX_DATA_IN,
   input wire logic [cprs_pkg::DINV_W-1:0] TX_DINV_IN,
   input wire logic RESP_DRIVE_IN,
   input wire logic [cprs_pkg::RESP_W-1:0] RESP_STATUS_IN,
   // core side receive
   output logic RX_VALID_OUT,
   output logic [cprs_pkg::REQ_W-1:0] RX_CMD_OUT,
   output logic [cprs_pkg::ADDR_W-1:0] RX_ADDR_OUT,
   output logic [cprs_pkg::DATA_W-1:0] RX_DATA_OUT,
   output logic [cprs_pkg::DINV_W-1:0] RX_DINV_OUT,
   output logic [cprs_pkg::RESP_W-1:0] RX_RESP_OUT,
   // request command pins, active low
   input wire logic [cprs_pkg::REQ_W-1:0] REQ_CMD_N_IN,
   output logic [cprs_pkg::REQ_W-1:0] REQ_CMD_N_OUT,
   output logic REQ_CMD_OE_OUT,
   // address strobe zero, active low
   input wire logic ADDRESS_STROBE0_N_IN,
   output logic ADDRESS_STROBE0_N_OUT,
   output logic ADDRESS_STROBE0_OE_OUT,
   // address pins, active low
   input wire logic [cprs_pkg::ADDR_W-1:0] ADDR_N_IN,
   output logic [cprs_pkg::ADDR_W-1:0] ADDR_N_OUT,
   output logic ADDR_OE_OUT,
   // data and inversion pins, active low
   input wire logic [cprs_pkg::DATA_W-1:0] DATA_N_IN,
   output logic [cprs_pkg::DATA_W-1:0] DATA_N_OUT,
   output logic DATA_OE_OUT,
   input wire logic [cprs_pkg::DINV_W-1:0] DATA_INVERSION_N_IN,
   output logic [cprs_pkg::DINV_W-1:0] DATA_INVERSION_N_OUT,
   output logic DATA_INVERSION_OE_OUT,
   // response status pins, active low
   input wire logic [cprs_pkg::RESP_W-1:0] RESPONSE_STATUS_N_IN,
   output logic [cprs_pkg::RESP_W-1:0] RESPONSE_STATUS_N_OUT,
   output logic RESPONSE_STATUS_OE_OUT
);
   //------------------------------------------------------------
   // declarations
   //------------------------------------------------------------
   cprs_pkg::cprs_state_e state_ff;
   cprs_pkg::cprs_state_e nxt_state;
   cprs_pkg::cprs_straps_s straps_ff;
   cprs_pkg::cprs_req_s rx_req_ff;
   logic in_reset;
   logic release_edge;
   logic may_drive;
   logic take_txn;
   logic por_pending_ff;
   logic [cprs_pkg::POR_CNT_W-1:0] por_cnt_ff;
   logic short_ff;
   logic rx_valid_ff;
   logic strobe_seen_ff;
   logic [cprs_pkg::ADDR_W-1:0] tx_addr_rev;
   logic [cprs_pkg::DATA_W-1:0] tx_data_rev;
   logic [cprs_pkg::DINV_W-1:0] tx_dinv_rev;
   logic [cprs_pkg::ADDR_W-1:0] rx_addr_rev;
   logic [cprs_pkg::DATA_W-1:0] rx_data_rev;
   logic [cprs_pkg::DINV_W-1:0] rx_dinv_rev;

   //------------------------------------------------------------
   // reset sequencing
   //------------------------------------------------------------
   // a low supply-ok is treated as reset too, so a controller slip cannot
   // leave the core running on bad rails
   assign in_reset = !RESET_N_IN || !SUPPLY_OK_IN;
   // straps and mode pins are sampled in the cycle reset first goes away
   assign release_edge = (state_ff == cprs_pkg::ST_IN_RESET) && !in_reset;

   // next state: any reset wins, float is held until the next reset
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         cprs_pkg::ST_IN_RESET: begin
            if (release_edge) begin
               nxt_state = SYS_MGMT_IRQ_N_IN ? cprs_pkg::ST_RELEASE
                                             : cprs_pkg::ST_FLOAT;
            end
         end
         cprs_pkg::ST_RELEASE: begin
            nxt_state = cprs_pkg::ST_RUN;
         end
         cprs_pkg::ST_RUN, cprs_pkg::ST_FLOAT: begin
            nxt_state = state_ff;
         end
      endcase
      if (in_reset) begin
         nxt_state = cprs_pkg::ST_IN_RESET;
      end
   end

   // state register
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         state_ff <= cprs_pkg::ST_IN_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // core held in known state and caches dropped without write-back
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         CORE_RESET_OUT <= 1'b1;
         CACHE_INVAL_OUT <= 1'b1;
      end else begin
         CORE_RESET_OUT <= in_reset || (state_ff == cprs_pkg::ST_IN_RESET);
         CACHE_INVAL_OUT <= in_reset;
      end
   end

   // strap capture on release, held until the next release
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         straps_ff <= '0;
      end else if (release_edge) begin
         straps_ff.cfg <= STRAP_CFG_IN;
         straps_ff.soft_init <= !INIT_N_IN;
         straps_ff.float_out <= !SYS_MGMT_IRQ_N_IN;
      end
   end

   assign STRAP_CFG_OUT = straps_ff.cfg;
   assign BIT_REVERSE_OUT = straps_ff.soft_init;
   assign OUTPUTS_FLOAT_OUT = (state_ff == cprs_pkg::ST_FLOAT);

   //------------------------------------------------------------
   // power-on reset length monitor
   //------------------------------------------------------------
   // counts reset cycles with good supply; only the reset that follows a
   // supply drop or a block reset is judged, a warm reset may be short
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         por_pending_ff <= 1'b1;
         por_cnt_ff <= cprs_pkg::POR_CNT_ZERO;
         short_ff <= 1'b0;
      end else begin
         if (!SUPPLY_OK_IN) begin
            por_pending_ff <= 1'b1;
            por_cnt_ff <= cprs_pkg::POR_CNT_ZERO;
         end else if (in_reset && (por_cnt_ff != '1)) begin
            por_cnt_ff <= por_cnt_ff + 1'b1;
         end
         if (release_edge && por_pending_ff) begin
            por_pending_ff <= 1'b0;
            short_ff <= (por_cnt_ff < POR_MIN_CYC[cprs_pkg::POR_CNT_W-1:0]);
         end
      end
   end

   assign RESET_SHORT_OUT = short_ff;

   //------------------------------------------------------------
   // bit order reversal for board layout
   //------------------------------------------------------------
   cprs_bitrev #(.W(cprs_pkg::ADDR_W)) u_tx_addr (.din_in(TXN_ADDR_IN),
      .rev_in(straps_ff.soft_init), .dout_out(tx_addr_rev));
   cprs_bitrev #(.W(cprs_pkg::DATA_W)) u_tx_data (.din_in(TX_DATA_IN),
      .rev_in(straps_ff.soft_init), .dout_out(tx_data_rev));
   cprs_bitrev #(.W(cprs_pkg::DINV_W)) u_tx_dinv (.din_in(TX_DINV_IN),
      .rev_in(straps_ff.soft_init), .dout_out(tx_dinv_rev));
   cprs_bitrev #(.W(cprs_pkg::ADDR_W)) u_rx_addr (.din_in(~ADDR_N_IN),
      .rev_in(straps_ff.soft_init), .dout_out(rx_addr_rev));
   cprs_bitrev #(.W(cprs_pkg::DATA_W)) u_rx_data (.din_in(~DATA_N_IN),
      .rev_in(straps_ff.soft_init), .dout_out(rx_data_rev));
   cprs_bitrev #(.W(cprs_pkg::DINV_W)) u_rx_dinv (.din_in(~DATA_INVERSION_N_IN),
      .rev_in(straps_ff.soft_init), .dout_out(rx_dinv_rev));

   //------------------------------------------------------------
   // bus drive
   //------------------------------------------------------------
   // drive only in run and with reset low; the enables fall on the first
   // edge that sees reset, one clock inside the two-clock allowance
   assign may_drive = (state_ff == cprs_pkg::ST_RUN) && !in_reset;
   assign TXN_READY_OUT = may_drive;
   assign take_txn = TXN_VALID_IN && may_drive;

   // command and address launch with the strobe in the same cycle, so the
   // far end captures them against the strobe, not the bus clock
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         REQ_CMD_N_OUT <= cprs_pkg::REQ_IDLE_N;
         REQ_CMD_OE_OUT <= 1'b0;
         ADDRESS_STROBE0_N_OUT <= 1'b1;
         ADDRESS_STROBE0_OE_OUT <= 1'b0;
         ADDR_N_OUT <= '1;
         ADDR_OE_OUT <= 1'b0;
      end else if (take_txn) begin
         REQ_CMD_N_OUT <= ~TXN_CMD_IN;
         REQ_CMD_OE_OUT <= 1'b1;
         ADDRESS_STROBE0_N_OUT <= 1'b0;
         ADDRESS_STROBE0_OE_OUT <= 1'b1;
         ADDR_N_OUT <= ~tx_addr_rev;
         ADDR_OE_OUT <= 1'b1;
      end else begin
         REQ_CMD_N_OUT <= cprs_pkg::REQ_IDLE_N;
         REQ_CMD_OE_OUT <= 1'b0;
         ADDRESS_STROBE0_N_OUT <= 1'b1;
         ADDRESS_STROBE0_OE_OUT <= 1'b0;
         ADDR_N_OUT <= '1;
         ADDR_OE_OUT <= 1'b0;
      end
   end

   // data and inversion follow the core's drive request each cycle
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         DATA_N_OUT <= '1;
         DATA_OE_OUT <= 1'b0;
         DATA_INVERSION_N_OUT <= '1;
         DATA_INVERSION_OE_OUT <= 1'b0;
      end else begin
         DATA_N_OUT <= ~tx_data_rev;
         DATA_OE_OUT <= DATA_DRIVE_IN && may_drive;
         DATA_INVERSION_N_OUT <= ~tx_dinv_rev;
         DATA_INVERSION_OE_OUT <= DATA_DRIVE_IN && may_drive;
      end
   end

   // response status driven only while this end completes the transaction
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         RESPONSE_STATUS_N_OUT <= cprs_pkg::RESP_IDLE_N;
         RESPONSE_STATUS_OE_OUT <= 1'b0;
      end else if (RESP_DRIVE_IN && may_drive) begin
         RESPONSE_STATUS_N_OUT <= ~RESP_STATUS_IN;
         RESPONSE_STATUS_OE_OUT <= 1'b1;
      end else begin
         RESPONSE_STATUS_N_OUT <= cprs_pkg::RESP_IDLE_N;
         RESPONSE_STATUS_OE_OUT <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // bus receive
   //------------------------------------------------------------
   // a request from the far agent is caught on the strobe's falling edge;
   // our own strobe is ignored so loopback does not echo a request
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         strobe_seen_ff <= 1'b0;
         rx_valid_ff <= 1'b0;
         rx_req_ff <= '0;
      end else begin
         strobe_seen_ff <= !ADDRESS_STROBE0_N_IN;
         rx_valid_ff <= 1'b0;
         if (!ADDRESS_STROBE0_N_IN && !strobe_seen_ff && !ADDRESS_STROBE0_OE_OUT
             && !in_reset) begin
            rx_req_ff.cmd <= ~REQ_CMD_N_IN;
            rx_req_ff.addr <= rx_addr_rev;
            rx_valid_ff <= 1'b1;
         end
      end
   end

   // data, inversion and response are sampled every cycle
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         RX_DATA_OUT <= '0;
         RX_DINV_OUT <= '0;
         RX_RESP_OUT <= '0;
      end else begin
         RX_DATA_OUT <= rx_data_rev;
         RX_DINV_OUT <= rx_dinv_rev;
         RX_RESP_OUT <= ~RESPONSE_STATUS_N_IN;
      end
   end

   assign RX_VALID_OUT = rx_valid_ff;
   assign RX_CMD_OUT = rx_req_ff.cmd;
   assign RX_ADDR_OUT = rx_req_ff.addr;
endmodule

// ### cprs_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus release, launch and capture checks
// ------------------------------------------------------------
module cprs_sva (
   // clock and block reset
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   // system controller
   input wire logic SUPPLY_OK_IN,
   input wire logic RESET_N_IN,
   // core side
   input wire logic TXN_VALID_IN,
   input wire logic [4:0] TXN_CMD_IN,
   input wire logic TXN_READY_OUT,
   input wire logic RESP_DRIVE_IN,
   input wire logic [2:0] RESP_STATUS_IN,
   input wire logic RX_VALID_OUT,
   input wire logic [4:0] RX_CMD_OUT,
   input wire logic CACHE_INVAL_OUT,
   input wire logic OUTPUTS_FLOAT_OUT,
   // bus pins
   input wire logic [4:0] REQ_CMD_N_IN,
   input wire logic [4:0] REQ_CMD_N_OUT,
   input wire logic REQ_CMD_OE_OUT,
   input wire logic ADDRESS_STROBE0_N_IN,
   input wire logic ADDRESS_STROBE0_N_OUT,
   input wire logic ADDRESS_STROBE0_OE_OUT,
   input wire logic ADDR_OE_OUT,
   input wire logic DATA_OE_OUT,
   input wire logic DATA_INVERSION_OE_OUT,
   input wire logic [2:0] RESPONSE_STATUS_N_OUT,
   input wire logic RESPONSE_STATUS_OE_OUT
);
   logic in_rst;
   logic oe_any;
   // device reset as the pins see it, and any pin being driven
   assign in_rst = !RESET_N_IN || !SUPPLY_OK_IN;
   assign oe_any = REQ_CMD_OE_OUT || ADDRESS_STROBE0_OE_OUT || ADDR_OE_OUT || DATA_OE_OUT
      || DATA_INVERSION_OE_OUT || RESPONSE_STATUS_OE_OUT;
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // checked every cycle of reset, so a long reset cannot drift back onto the bus
   a_bus_release: assert property (in_rst |=> !oe_any)
      else $error("bus still driven during device reset");
   a_ready_reset: assert property (in_rst |-> !TXN_READY_OUT)
      else $error("request accepted during device reset");
   a_cache_track: assert property (1'b1 |=> CACHE_INVAL_OUT == $past(in_rst))
      else $error("cache invalidate does not follow reset");
   a_req_launch: assert property (TXN_VALID_IN && TXN_READY_OUT
      |=> REQ_CMD_OE_OUT && ADDRESS_STROBE0_OE_OUT && !ADDRESS_STROBE0_N_OUT
      && REQ_CMD_N_OUT == ~$past(TXN_CMD_IN))
      else $error("request command not launched with strobe");
   a_req_single: assert property (!(TXN_VALID_IN && TXN_READY_OUT)
      |=> !REQ_CMD_OE_OUT && !ADDRESS_STROBE0_OE_OUT)
      else $error("request lines driven without a request");
   a_rx_capture: assert property (!ADDRESS_STROBE0_N_IN
      && $past(ADDRESS_STROBE0_N_IN) && !ADDRESS_STROBE0_OE_OUT && !in_rst
      |=> RX_VALID_OUT && RX_CMD_OUT == ~$past(REQ_CMD_N_IN))
      else $error("far request not captured at strobe");
   a_rx_pulse: assert property (RX_VALID_OUT |=> !RX_VALID_OUT)
      else $error("capture pulse longer than one cycle");
   a_resp_drive: assert property (RESP_DRIVE_IN && TXN_READY_OUT
      |=> RESPONSE_STATUS_OE_OUT && RESPONSE_STATUS_N_OUT == ~$past(RESP_STATUS_IN))
      else $error("response status not driven as asked");
   a_float_quiet: assert property (OUTPUTS_FLOAT_OUT |-> !oe_any && !TXN_READY_OUT)
      else $error("outputs driven in float state");
   // main scenarios reached
   c_tx_take: cover property (TXN_VALID_IN && TXN_READY_OUT);
   c_rx_take: cover property (RX_VALID_OUT);
   c_float: cover property (OUTPUTS_FLOAT_OUT);
endmodule

// ### cprs_partner.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far bus agent with line resolution
// ------------------------------------------------------------
module cprs_partner (
   // clock and the device reset it observes
   input wire logic clk_in,
   input wire logic dev_rst_in,
   // requests and responses to launch
   input wire logic go_in,
   input wire cprs_pkg::cprs_req_s req_in,
   input wire logic rs_go_in,
   input wire logic [2:0] rs_in,
   // device drive
   input wire logic dut_oe_in,
   input wire cprs_pkg::cprs_req_s dut_req_n_in,
   input wire logic dut_stb_n_in,
   input wire logic dut_rs_oe_in,
   input wire logic [2:0] dut_rs_n_in,
   // resolved wires
   output cprs_pkg::cprs_req_s req_n_out,
   output logic stb_n_out,
   output logic [2:0] rs_n_out
);
   logic drv_ff;
   logic rs_drv_ff;
   cprs_pkg::cprs_req_s req_ff;
   logic [2:0] rs_ff;
   // launch just after an edge; a seen reset drops the drive at the next edge
   always_ff @(posedge clk_in) begin
      drv_ff <= go_in && !dev_rst_in;
      req_ff <= ~req_in;
      rs_drv_ff <= rs_go_in && !dev_rst_in;
      rs_ff <= ~rs_in;
   end
   // released lines sit at the termination level, all ones
   assign stb_n_out = dut_oe_in ? dut_stb_n_in : !drv_ff;
   assign req_n_out = dut_oe_in ? dut_req_n_in : (drv_ff ? req_ff : '1);
   assign rs_n_out = dut_rs_oe_in ? dut_rs_n_in : (rs_drv_ff ? rs_ff : 3'h7);
endmodule

// ### cprs_top_bench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// self-checking bench for the reset sequencer
// ------------------------------------------------------------
module cprs_top_bench;
   localparam int POR = 20;
   logic CLK_IN = 0, RSTN_IN = 0, SUPPLY_OK_IN = 0, RESET_N_IN = 0, INIT_N_IN = 1;
   logic SYS_MGMT_IRQ_N_IN = 1, TXN_VALID_IN = 0, DATA_DRIVE_IN = 0, RESP_DRIVE_IN = 0;
   logic [7:0] STRAP_CFG_IN = 0, STRAP_CFG_OUT, d8;
   logic [4:0] TXN_CMD_IN = 0, RX_CMD_OUT, REQ_CMD_N_IN, REQ_CMD_N_OUT;
   logic [28:0] TXN_ADDR_IN = 0, RX_ADDR_OUT, ADDR_N_IN, ADDR_N_OUT, a;
   logic [63:0] TX_DATA_IN = 0, p_data = 0, RX_DATA_OUT, DATA_N_IN, DATA_N_OUT, d_prev, pv_d;
   logic [3:0] TX_DINV_IN = 0, p_dinv = 0, RX_DINV_OUT, DATA_INVERSION_N_IN, DATA_INVERSION_N_OUT;
   logic [2:0] RESP_STATUS_IN = 0, p_rs = 0, RX_RESP_OUT, RESPONSE_STATUS_N_IN;
   logic [2:0] RESPONSE_STATUS_N_OUT, pv_rs;
   logic [3:0] pv_dv, dv_prev;
   logic CORE_RESET_OUT, CACHE_INVAL_OUT, BIT_REVERSE_OUT, OUTPUTS_FLOAT_OUT, RESET_SHORT_OUT;
   logic TXN_READY_OUT, RX_VALID_OUT, REQ_CMD_OE_OUT, ADDRESS_STROBE0_N_IN, ADDR_OE_OUT;
   logic ADDRESS_STROBE0_N_OUT, ADDRESS_STROBE0_OE_OUT, DATA_OE_OUT;
   logic DATA_INVERSION_OE_OUT, RESPONSE_STATUS_OE_OUT, oe_any, p_go = 0, p_rs_go = 0;
   logic rx_on = 0, last = 0;
   logic [8:0] pat = 9'h075;
   cprs_pkg::cprs_req_s p_req = '0, req_w, pv, r, r2;
   cprs_pkg::cprs_req_s exp_q[$];
   int failures = 0, compares = 0, cycles = 0, i;

   always #12.5 CLK_IN = !CLK_IN;
   // the far agent keeps a moving pattern on the data lines whenever the device lets go
   assign DATA_N_IN = DATA_OE_OUT ? DATA_N_OUT : p_data;
   assign DATA_INVERSION_N_IN = DATA_INVERSION_OE_OUT ? DATA_INVERSION_N_OUT : p_dinv;
   assign REQ_CMD_N_IN = req_w.cmd;
   assign ADDR_N_IN = req_w.addr;
   assign oe_any = REQ_CMD_OE_OUT || ADDRESS_STROBE0_OE_OUT || ADDR_OE_OUT || DATA_OE_OUT
      || DATA_INVERSION_OE_OUT || RESPONSE_STATUS_OE_OUT;

   cprs_top #(.POR_MIN_CYC(POR)) u_cprs_top (.*);
   cprs_partner u_cprs_partner (.clk_in(CLK_IN), .dev_rst_in(!RESET_N_IN || !SUPPLY_OK_IN),
      .go_in(p_go), .req_in(p_req), .rs_go_in(p_rs_go), .rs_in(p_rs),
      .dut_oe_in(REQ_CMD_OE_OUT), .dut_req_n_in({REQ_CMD_N_OUT, ADDR_N_OUT}),
      .dut_stb_n_in(ADDRESS_STROBE0_N_OUT), .dut_rs_oe_in(RESPONSE_STATUS_OE_OUT),
      .dut_rs_n_in(RESPONSE_STATUS_N_OUT), .req_n_out(req_w), .stb_n_out(ADDRESS_STROBE0_N_IN),
      .rs_n_out(RESPONSE_STATUS_N_IN));

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_IN);
   endtask
   function automatic logic [28:0] rev29(input logic [28:0] v);
      for (int k = 0; k < 29; k++) rev29[k] = v[28 - k];
   endfunction
   // hold the device in reset, optionally from a supply drop, then release it
   task automatic dev_reset(input int n, input logic pwr, input logic init_n, input logic irq_n);
      @(posedge CLK_IN);
      RESET_N_IN <= 0;
      if (pwr) SUPPLY_OK_IN <= 0;
      tick(3);
      SUPPLY_OK_IN <= 1;
      STRAP_CFG_IN <= 8'($urandom);
      INIT_N_IN <= init_n;
      SYS_MGMT_IRQ_N_IN <= irq_n;
      tick(n);
      RESET_N_IN <= 1;
      tick(3);
      #1;
   endtask

   // cycle limit, far-side pattern and the rx data model
   always @(posedge CLK_IN) begin
      d_prev <= DATA_N_IN;
      dv_prev <= DATA_INVERSION_N_IN;
      p_data <= {$urandom, $urandom};
      p_dinv <= 4'($urandom);
      cycles++;
      if (cycles == 2000) begin
         failures++;
         test_done();
      end
   end
   // each capture must match the oldest request the far agent launched
   always @(negedge CLK_IN) begin
      if (RX_VALID_OUT === 1'b1) begin
         r2 = exp_q.size() > 0 ? exp_q.pop_front() : '1;
         chk("rx_cmd", RX_CMD_OUT, r2.cmd);
         chk("rx_addr", RX_ADDR_OUT, r2.addr);
      end
      if (rx_on) chk("rx_data", RX_DATA_OUT, ~d_prev);
      if (rx_on) chk("rx_dinv", RX_DINV_OUT, {~dv_prev});
   end

   initial begin
      void'($urandom(32'ha6c7));
      tick(4);
      RSTN_IN <= 1;
      #1;
      chk("core_reset", CORE_RESET_OUT, 1'h1);
      chk("oe_any", oe_any, 1'h0);
      $display("test block_reset done");
      dev_reset(POR + 2, 1, 1, 1);
      d8 = STRAP_CFG_IN;
      chk("ready", TXN_READY_OUT, 1'h1);
      chk("straps", STRAP_CFG_OUT, d8);
      chk("short", RESET_SHORT_OUT, 1'h0);
      chk("inval", CACHE_INVAL_OUT, 1'h0);
      chk("core_run", CORE_RESET_OUT, 1'h0);
      $display("test power_on done");
      // every command code back to back, with data and response driven alongside
      for (i = 0; i <= 32; i++) begin
         @(posedge CLK_IN);
         if (i == 0) STRAP_CFG_IN <= ~d8;
         TXN_VALID_IN <= (i < 32);
         DATA_DRIVE_IN <= (i < 32);
         RESP_DRIVE_IN <= (i < 32);
         TXN_CMD_IN <= i[4:0];
         TXN_ADDR_IN <= 29'($urandom);
         TX_DATA_IN <= {$urandom, $urandom};
         TX_DINV_IN <= 4'($urandom);
         RESP_STATUS_IN <= i[2:0];
         #1;
         if (i > 0) begin
            chk("req_cmd", REQ_CMD_N_OUT, {~pv.cmd});
            chk("req_addr", ADDR_N_OUT, {~pv.addr});
            chk("strobe", {ADDRESS_STROBE0_OE_OUT, ADDRESS_STROBE0_N_OUT}, 2'h2);
            chk("data", DATA_N_OUT, ~pv_d);
            chk("dinv", DATA_INVERSION_N_OUT, {~pv_dv});
            chk("resp", RESPONSE_STATUS_N_OUT, {~pv_rs});
         end
         pv = {TXN_CMD_IN, TXN_ADDR_IN};
         pv_d = TX_DATA_IN;
         pv_dv = TX_DINV_IN;
         pv_rs = RESP_STATUS_IN;
      end
      @(posedge CLK_IN);
      #1;
      chk("oe_idle", oe_any, 1'h0);
      chk("straps_held", STRAP_CFG_OUT, d8);
      $display("test transmit done");
      // far requests at the minimum gap, then one strobe held low for three cycles
      rx_on = 1;
      for (i = 0; i < 9; i++) begin
         @(posedge CLK_IN);
         p_rs_go <= 1;
         p_rs <= 3'h5;
         p_go <= pat[i];
         r.cmd = 5'($urandom);
         r.addr = 29'($urandom);
         if (pat[i] && !last) begin
            p_req <= r;
            exp_q.push_back(r);
         end
         last = pat[i];
      end
      tick(3);
      #1;
      rx_on = 0;
      chk("rx_left", exp_q.size(), 64'h0);
      chk("rx_resp", RX_RESP_OUT, 3'h5);
      $display("test receive done");
      // reset lands while a request is on the bus
      @(posedge CLK_IN);
      TXN_VALID_IN <= 1;
      DATA_DRIVE_IN <= 1;
      @(posedge CLK_IN);
      RESET_N_IN <= 0;
      #1;
      chk("ready_drop", TXN_READY_OUT, 1'h0);
      chk("driving", oe_any, 1'h1);
      tick(2);
      #1;
      chk("released", oe_any, 1'h0);
      chk("inval_on", CACHE_INVAL_OUT, 1'h1);
      chk("core_hold", CORE_RESET_OUT, 1'h1);
      dev_reset(4, 0, 0, 1);
      a = TXN_ADDR_IN;
      @(posedge CLK_IN);
      #1;
      chk("bitrev", BIT_REVERSE_OUT, 1'h1);
      chk("rev_addr", ADDR_N_OUT, {~rev29(a)});
      chk("warm_short", RESET_SHORT_OUT, 1'h0);
      $display("test warm_reset done");
      // too short a power-on reset with the management irq low at release
      dev_reset(POR - 5, 1, 1, 0);
      chk("short_set", RESET_SHORT_OUT, 1'h1);
      chk("float", OUTPUTS_FLOAT_OUT, 1'h1);
      tick(3);
      #1;
      chk("float_quiet", oe_any, 1'h0);
      $display("test float done");
      test_done();
   end
endmodule

bind cprs_top cprs_sva u_sva (.*);
